// ===== logic/kpm_pkg.sv
// package: constants and types of the keypad parameter menu
`default_nettype none
package kpm_pkg;
	// menu ring: monitor items, basic codes, extended group entries
	localparam logic [3:0] MENU_FIRST_MON = 4'h0;
	localparam logic [3:0] MENU_LAST_MON = 4'h8;
	localparam logic [3:0] MENU_FIRST_F = 4'h9;
	localparam logic [3:0] MENU_ACCEL1 = 4'ha;
	localparam logic [3:0] MENU_GRP_A = 4'hd;
	localparam int N_BASIC = 4;
	localparam int SUB_W = 7;
	// group numbers and parameter positions inside a group
	localparam int G_A = 0;
	localparam int G_B = 1;
	localparam int G_C = 2;
	localparam int K_SP_SRC = 0;
	localparam int K_START_SRC = 1;
	localparam int K_BASE_FREQ = 2;
	localparam int K_IN_FN0 = 0;
	localparam int K_METER_SEL = 22;
	localparam int K_METER_GAIN = 80;
	localparam int B_ACCEL1 = 1;
	// factory values, tenths where the value has a decimal point
	localparam logic [15:0] DEF_ACCEL1 = 16'h0064;
	localparam logic [15:0] DEF_BASE_FREQ = 16'h01f4;
	localparam logic [15:0] DEF_SP_SRC = 16'h0001;
	localparam logic [15:0] DEF_START_SRC = 16'h0001;
	localparam logic [15:0] DEF_IN_FN1 = 16'h0001;
	localparam logic [15:0] DEF_IN_FN2 = 16'h0010;
	localparam logic [15:0] DEF_METER_GAIN = 16'h0050;
	// selector and function codes
	localparam logic [15:0] SRC_TERMINAL = 16'h0001;
	localparam logic [15:0] FN_CW = 16'h0000;
	localparam logic [15:0] FN_ACW = 16'h0001;
	localparam logic [15:0] FN_AT = 16'h0010;
	localparam logic [15:0] METER_CURRENT = 16'h0001;
	localparam logic [31:0] METER_GAIN_DIV = 32'h0000_0064;
	// key debounce time
	localparam int DEBOUNCE_US = 10000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int DEB_CYCLES = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
	// register offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_VALUE = 8'h04;
	localparam logic [7:0] REG_PINDEX = 8'h08;
	localparam logic [7:0] REG_PDATA = 8'h0c;
	typedef enum logic [1:0] {ST_DISP, ST_MENU, ST_GRP, ST_EDIT} kpm_state_t;
	typedef struct packed {
		logic stop;
		logic enter;
		logic down;
		logic up;
		logic program_key;
	} kpm_keys_t;
	typedef struct packed {
		logic run_fwd;
		logic run_rev;
		logic sp_term;
		logic start_term;
		logic sp_current;
	} kpm_term_t;
	typedef struct packed {
		logic prg_lamp;
		kpm_state_t mode;
		logic [3:0] entry;
		logic [SUB_W-1:0] sub;
		logic [15:0] value;
	} kpm_disp_t;
endpackage
`default_nettype wire

// ===== logic/kpm_menu.sv
// file: keypad parameter menu with terminal control and meter output
//
// Our own choices: the placing of the registers and register access over APB.
`default_nettype none
module kpm_menu
	import kpm_pkg::*;
#(
	parameter int DEB_CYC = DEB_CYCLES,
	parameter int GRP_N = 96,
	parameter int N_DIN = 5,
	parameter logic [15:0] VAL_MAX = 16'hffff
)(
	input wire logic MCLK, // 100 MHz clock
	input wire logic RSTN, // synchronous reset, power-up
	input wire logic FACTORY_N, // loads factory values into retained state
	input wire kpm_keys_t KEYS, // raw keypad keys, high while pressed
	input wire logic [N_DIN-1:0] DIN, // digital input terminals
	input wire logic [15:0] FREQ_IN, // present output frequency
	input wire logic [15:0] CURR_IN, // present motor current
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb enable
	input wire logic PWRITE, // apb direction
	input wire logic [7:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error on unmapped address
	output kpm_disp_t DISP, // display contents and lamp
	output kpm_term_t TERM, // run and setpoint control
	output logic [15:0] METER_OUT, // analog meter output value
	output logic FAULT_ACK // fault acknowledge pulse
);
	localparam int NPAR = N_BASIC + 3 * GRP_N;
	localparam int PW = $clog2(NPAR);
	localparam int DW = $clog2(DEB_CYC + 1);
	localparam int P_ACCEL1 = B_ACCEL1;
	localparam int P_SP_SRC = N_BASIC + G_A * GRP_N + K_SP_SRC;
	localparam int P_START_SRC = N_BASIC + G_A * GRP_N + K_START_SRC;
	localparam int P_BASE_FREQ = N_BASIC + G_A * GRP_N + K_BASE_FREQ;
	localparam int P_IN_FN0 = N_BASIC + G_C * GRP_N + K_IN_FN0;
	localparam int P_METER_SEL = N_BASIC + G_C * GRP_N + K_METER_SEL;
	localparam int P_METER_GAIN = N_BASIC + G_B * GRP_N + K_METER_GAIN;

	// ==========================================================
	// key debounce
	logic [4:0] key_raw;
	logic [4:0] key_hit;
	kpm_keys_t hit;
	assign key_raw = KEYS;
	assign hit = key_hit;

	// a level must stay changed for the whole debounce time to count
	for (genvar i = 0; i < 5; i++)
	begin : g_deb
		logic [DW-1:0] cnt_q;
		logic stb_q;
		logic hit_q;
		always_ff @(posedge MCLK)
		begin
			if (!RSTN)
			begin
				cnt_q <= '0;
				stb_q <= 1'b0;
				hit_q <= 1'b0;
			end
			else if (key_raw[i] == stb_q)
			begin
				cnt_q <= '0;
				hit_q <= 1'b0;
			end
			else if (cnt_q == DW'(DEB_CYC - 1))
			begin
				cnt_q <= '0;
				stb_q <= key_raw[i];
				hit_q <= key_raw[i];
			end
			else
			begin
				cnt_q <= cnt_q + DW'(1);
				hit_q <= 1'b0;
			end
		end
		assign key_hit[i] = hit_q;
	end

	// ==========================================================
	// menu state
	kpm_state_t st_q;
	logic [3:0] menu_q;
	logic [SUB_W-1:0] sub_q;
	logic [15:0] edit_q;
	logic back_q;
	logic [15:0] vals_q [NPAR];
	logic [PW-1:0] cur_pi;
	kpm_state_t nv_st_q;
	logic [3:0] nv_menu_q;
	logic [3:0] mon_sel_q;
	logic mod_ok_q;
	logic [3:0] mod_menu_q;
	logic [SUB_W-1:0] mod_sub_q;
	logic in_grp;
	logic key_wr;
	logic [SUB_W-1:0] sub_last;

	assign in_grp = (menu_q >= MENU_GRP_A);
	assign key_wr = (st_q == ST_EDIT) && !hit.program_key && hit.enter;
	assign sub_last = SUB_W'(GRP_N - 1);

	// storage slot of the code under the cursor
	always_comb
	begin
		if (in_grp)
			cur_pi = PW'(N_BASIC + int'(menu_q - MENU_GRP_A) * GRP_N + int'(sub_q));
		else
			cur_pi = PW'(menu_q - MENU_FIRST_F);
	end

	// menu walk; the program key outranks the others when pressed together
	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
		begin
			st_q <= nv_st_q;
			menu_q <= nv_menu_q;
			sub_q <= '0;
			edit_q <= '0;
			back_q <= 1'b0;
		end
		else
		begin
			case (st_q)
			ST_DISP:
				if (hit.program_key)
				begin
					st_q <= (mod_ok_q && mod_menu_q >= MENU_GRP_A) ? ST_GRP : ST_MENU;
					menu_q <= mod_ok_q ? mod_menu_q : MENU_FIRST_MON;
					sub_q <= mod_sub_q;
					back_q <= 1'b0;
				end
			ST_MENU:
				if (hit.program_key)
				begin
					if (menu_q <= MENU_LAST_MON)
						st_q <= ST_DISP;
					else if (in_grp)
					begin
						st_q <= ST_GRP;
						sub_q <= '0;
						back_q <= 1'b0;
					end
					else
					begin
						st_q <= ST_EDIT;
						edit_q <= vals_q[cur_pi];
					end
				end
				else if (hit.up)
					menu_q <= menu_q + 4'h1;
				else if (hit.down)
					menu_q <= menu_q - 4'h1;
			ST_GRP:
				if (hit.program_key)
				begin
					// the first press after an edit leaves, a fresh one opens
					if (back_q)
						st_q <= ST_MENU;
					else
					begin
						st_q <= ST_EDIT;
						edit_q <= vals_q[cur_pi];
					end
				end
				else if (hit.up)
				begin
					sub_q <= (sub_q == sub_last) ? '0 : sub_q + SUB_W'(1);
					back_q <= 1'b0;
				end
				else if (hit.down)
				begin
					sub_q <= (sub_q == '0) ? sub_last : sub_q - SUB_W'(1);
					back_q <= 1'b0;
				end
			ST_EDIT:
				if (hit.program_key || hit.enter)
				begin
					st_q <= in_grp ? ST_GRP : ST_MENU;
					back_q <= in_grp;
				end
				else if (hit.up && edit_q != VAL_MAX)
					edit_q <= edit_q + 16'h0001;
				else if (hit.down && edit_q != 16'h0000)
					edit_q <= edit_q - 16'h0001;
			default:
				st_q <= ST_DISP;
			endcase
		end
	end

	// ==========================================================
	// retained state: only the factory load clears it, not power-up
	always_ff @(posedge MCLK)
	begin
		if (!FACTORY_N)
		begin
			nv_st_q <= ST_DISP;
			nv_menu_q <= MENU_FIRST_MON;
			mon_sel_q <= MENU_FIRST_MON;
			mod_ok_q <= 1'b0;
			mod_menu_q <= MENU_FIRST_MON;
			mod_sub_q <= '0;
		end
		else if (RSTN)
		begin
			// screens inside a group are never recorded
			if (st_q == ST_DISP || st_q == ST_MENU || (st_q == ST_EDIT && !in_grp))
			begin
				nv_st_q <= (st_q == ST_DISP) ? ST_DISP : ST_MENU;
				nv_menu_q <= menu_q;
			end
			if (st_q == ST_MENU && hit.program_key && menu_q <= MENU_LAST_MON)
				mon_sel_q <= menu_q;
			if (key_wr)
			begin
				mod_ok_q <= 1'b1;
				mod_menu_q <= menu_q;
				mod_sub_q <= sub_q;
			end
		end
	end

	// ==========================================================
	// parameter values, retained; the keypad wins over a bus write
	logic bus_wr;
	logic [PW-1:0] pidx_q;

	always_ff @(posedge MCLK)
	begin
		if (!FACTORY_N)
		begin
			for (int i = 0; i < NPAR; i++)
				vals_q[i] <= 16'h0000;
			vals_q[P_ACCEL1] <= DEF_ACCEL1;
			vals_q[P_BASE_FREQ] <= DEF_BASE_FREQ;
			vals_q[P_SP_SRC] <= DEF_SP_SRC;
			vals_q[P_START_SRC] <= DEF_START_SRC;
			vals_q[P_IN_FN0 + 1] <= DEF_IN_FN1;
			vals_q[P_IN_FN0 + 2] <= DEF_IN_FN2;
			vals_q[P_METER_GAIN] <= DEF_METER_GAIN;
		end
		else if (RSTN && key_wr)
			vals_q[cur_pi] <= edit_q;
		else if (RSTN && bus_wr && PADDR == REG_PDATA && int'(pidx_q) < NPAR)
			vals_q[pidx_q] <= PWDATA[15:0];
	end

	// ==========================================================
	// terminal control
	logic [N_DIN-1:0] cw_v;
	logic [N_DIN-1:0] acw_v;
	logic [N_DIN-1:0] at_v;
	logic start_term;
	logic sp_term;
	logic fwd_req;
	logic rev_req;
	logic stop_hold_q;

	// each input's function comes from its own code in group C
	for (genvar i = 0; i < N_DIN; i++)
	begin : g_din
		assign cw_v[i] = DIN[i] && vals_q[P_IN_FN0 + i] == FN_CW;
		assign acw_v[i] = DIN[i] && vals_q[P_IN_FN0 + i] == FN_ACW;
		assign at_v[i] = DIN[i] && vals_q[P_IN_FN0 + i] == FN_AT;
	end

	assign start_term = (vals_q[P_START_SRC] == SRC_TERMINAL);
	assign sp_term = (vals_q[P_SP_SRC] == SRC_TERMINAL);
	assign fwd_req = start_term && (|cw_v);
	assign rev_req = start_term && (|acw_v);

	// stop key holds the drive off until both run inputs are released
	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
			stop_hold_q <= 1'b0;
		else if (hit.stop)
			stop_hold_q <= 1'b1;
		else if (!fwd_req && !rev_req)
			stop_hold_q <= 1'b0;
	end

	// run outputs; a request on both directions is a stop
	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
		begin
			TERM <= '0;
			FAULT_ACK <= 1'b0;
		end
		else
		begin
			TERM.run_fwd <= fwd_req && !rev_req && !stop_hold_q && !hit.stop;
			TERM.run_rev <= rev_req && !fwd_req && !stop_hold_q && !hit.stop;
			TERM.sp_term <= sp_term;
			TERM.start_term <= start_term;
			TERM.sp_current <= sp_term && (|at_v);
			FAULT_ACK <= hit.stop;
		end
	end

	// ==========================================================
	// analog meter output, saturated rather than wrapped
	logic [15:0] meter_src;
	logic [31:0] meter_prod;
	logic [31:0] meter_div;
	assign meter_src = (vals_q[P_METER_SEL] == METER_CURRENT) ? CURR_IN : FREQ_IN;
	assign meter_prod = {16'h0000, meter_src} * {16'h0000, vals_q[P_METER_GAIN]};
	assign meter_div = meter_prod / METER_GAIN_DIV;

	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
			METER_OUT <= 16'h0000;
		else
			METER_OUT <= (meter_div > 32'h0000_ffff) ? 16'hffff : meter_div[15:0];
	end

	// ==========================================================
	// display
	logic [15:0] mon_val;
	always_comb
	begin
		case (mon_sel_q)
		4'h0: mon_val = FREQ_IN;
		4'h1: mon_val = CURR_IN;
		4'h4: mon_val = 16'(DIN);
		default: mon_val = 16'h0000;
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
			DISP <= '0;
		else
		begin
			DISP.prg_lamp <= (st_q != ST_DISP);
			DISP.mode <= st_q;
			DISP.entry <= (st_q == ST_DISP) ? mon_sel_q : menu_q;
			DISP.sub <= sub_q;
			DISP.value <= (st_q == ST_EDIT) ? edit_q : mon_val;
		end
	end

	// ==========================================================
	// apb slave, no wait states
	logic [31:0] rd_d;
	logic mapped;
	assign mapped = (PADDR == REG_STATUS) || (PADDR == REG_VALUE) ||
		(PADDR == REG_PINDEX) || (PADDR == REG_PDATA);
	assign bus_wr = PSEL && PENABLE && PWRITE && mapped;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;

	always_comb
	begin
		case (PADDR)
		// status is 23 bits used, so nine zero bits pad it to the word
		REG_STATUS: rd_d = {9'h000, TERM, stop_hold_q, mod_ok_q, 1'b0, sub_q,
			menu_q, 2'b00, st_q};
		REG_VALUE: rd_d = {16'h0000, DISP.value};
		REG_PINDEX: rd_d = 32'(pidx_q);
		REG_PDATA: rd_d = (int'(pidx_q) < NPAR) ? {16'h0000, vals_q[pidx_q]} : 32'h0;
		default: rd_d = 32'h0000_0000;
		endcase
	end

	// read data is caught in the setup cycle so it stands through access
	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
			PRDATA <= 32'h0000_0000;
		else if (PSEL && !PENABLE && !PWRITE)
			PRDATA <= rd_d;
	end

	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
			pidx_q <= '0;
		else if (bus_wr && PADDR == REG_PINDEX)
			pidx_q <= PWDATA[PW-1:0];
	end

	// ==========================================================
	// checks
	a_lamp_on_entry: assert property (@(posedge MCLK) disable iff (!RSTN)
		st_q == ST_DISP && hit.program_key |=> ##1 DISP.prg_lamp)
		else $error("lamp not lit after entering programming");
	a_menu_up_step: assert property (@(posedge MCLK) disable iff (!RSTN)
		st_q == ST_MENU && hit.up && !hit.program_key |=> menu_q == $past(menu_q) + 4'h1)
		else $error("up key did not step the menu");
	a_first_item: assert property (@(posedge MCLK) disable iff (!RSTN)
		st_q == ST_DISP && hit.program_key && !mod_ok_q |=> st_q == ST_MENU && menu_q == MENU_FIRST_MON)
		else $error("entry did not show first monitor item");
	a_mon_return: assert property (@(posedge MCLK) disable iff (!RSTN)
		st_q == ST_MENU && hit.program_key && menu_q <= MENU_LAST_MON
		|=> st_q == ST_DISP && mon_sel_q == $past(menu_q))
		else $error("monitor item did not return to display");
	a_open_value: assert property (@(posedge MCLK) disable iff (!RSTN || !FACTORY_N)
		st_q == ST_MENU && hit.program_key && menu_q >= MENU_FIRST_F && !in_grp
		|=> st_q == ST_EDIT && edit_q == vals_q[$past(cur_pi)])
		else $error("value not opened");
	a_accept_store: assert property (@(posedge MCLK) disable iff (!RSTN || !FACTORY_N)
		key_wr |=> st_q != ST_EDIT && vals_q[$past(cur_pi)] == $past(edit_q))
		else $error("accepted value not stored");
	a_group_first: assert property (@(posedge MCLK) disable iff (!RSTN)
		st_q == ST_MENU && hit.program_key && in_grp |=> st_q == ST_GRP && sub_q == '0)
		else $error("group not entered at first code");
	a_group_leave: assert property (@(posedge MCLK) disable iff (!RSTN)
		st_q == ST_GRP && hit.program_key && back_q |=> st_q == ST_MENU && $stable(menu_q))
		else $error("group not left");
	a_both_stop: assert property (@(posedge MCLK) disable iff (!RSTN)
		fwd_req && rev_req |=> !TERM.run_fwd && !TERM.run_rev)
		else $error("both run inputs did not stop");
	a_stop_key: assert property (@(posedge MCLK) disable iff (!RSTN)
		hit.stop |=> !TERM.run_fwd && !TERM.run_rev && FAULT_ACK)
		else $error("stop key did not stop the drive");
endmodule
`default_nettype wire

// ===== tb/kpm_operator.sv
// operator model: a person pressing the keypad keys
`default_nettype none
module kpm_operator
	import kpm_pkg::*;
#(
	parameter int HOLD = 8
)(
	input wire logic mclk, // keypad sampling clock
	output var kpm_keys_t keys // key levels, high while pressed
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// key actions
	initial keys = '0;

	// one clean press, held and released past the filter time
	task automatic press(input int k);
	begin
		@(posedge mclk);
		keys[k] <= 1'b1;
		repeat (HOLD) @(posedge mclk);
		keys[k] <= 1'b0;
		repeat (HOLD) @(posedge mclk);
	end
	endtask

	// contact bounce shorter than the filter; the menu must not move
	task automatic bounce(input int k, input int n);
	begin
		@(posedge mclk);
		keys[k] <= 1'b1;
		repeat (n) @(posedge mclk);
		keys[k] <= 1'b0;
		repeat (2 * HOLD) @(posedge mclk);
	end
	endtask
endmodule
`default_nettype wire

// ===== tb/kpm_menu_tb_top.sv
// testbench: keypad walk, restore, terminal control, meter and registers
`default_nettype none
module kpm_menu_tb_top
	import kpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// stimulus tables
	// short filter keeps each key press at sixteen cycles
	localparam int DEB = 4;
	localparam int KP = 0, KU = 1, KD = 2, KE = 3, KS = 4;
	typedef struct packed {
		logic [2:0] key;
		kpm_state_t mode;
		logic [3:0] entry;
		logic [6:0] sub;
		logic chk;
		logic [15:0] value;
	} kpm_row_t;
	kpm_row_t rows [37] = '{
		'{KP,ST_MENU,4'h0,7'h0,0,16'h0}, '{KD,ST_MENU,4'hf,7'h0,0,16'h0},
		'{KD,ST_MENU,4'he,7'h0,0,16'h0}, '{KD,ST_MENU,4'hd,7'h0,0,16'h0},
		'{KD,ST_MENU,4'hc,7'h0,0,16'h0}, '{KD,ST_MENU,4'hb,7'h0,0,16'h0},
		'{KD,ST_MENU,4'ha,7'h0,0,16'h0}, '{KP,ST_EDIT,4'ha,7'h0,1,16'h0064},
		'{KU,ST_EDIT,4'ha,7'h0,1,16'h0065}, '{KE,ST_MENU,4'ha,7'h0,0,16'h0},
		'{KP,ST_EDIT,4'ha,7'h0,1,16'h0065}, '{KD,ST_EDIT,4'ha,7'h0,1,16'h0064},
		'{KP,ST_MENU,4'ha,7'h0,0,16'h0}, '{KP,ST_EDIT,4'ha,7'h0,1,16'h0065},
		'{KP,ST_MENU,4'ha,7'h0,0,16'h0}, '{KU,ST_MENU,4'hb,7'h0,0,16'h0},
		'{KU,ST_MENU,4'hc,7'h0,0,16'h0}, '{KU,ST_MENU,4'hd,7'h0,0,16'h0},
		'{KU,ST_MENU,4'he,7'h0,0,16'h0}, '{KU,ST_MENU,4'hf,7'h0,0,16'h0},
		'{KU,ST_MENU,4'h0,7'h0,0,16'h0}, '{KP,ST_DISP,4'h0,7'h0,1,16'h1234},
		'{KP,ST_MENU,4'ha,7'h0,0,16'h0}, '{KU,ST_MENU,4'hb,7'h0,0,16'h0},
		'{KU,ST_MENU,4'hc,7'h0,0,16'h0}, '{KU,ST_MENU,4'hd,7'h0,0,16'h0},
		'{KP,ST_GRP,4'hd,7'h0,0,16'h0}, '{KU,ST_GRP,4'hd,7'h1,0,16'h0},
		'{KU,ST_GRP,4'hd,7'h2,0,16'h0}, '{KP,ST_EDIT,4'hd,7'h0,1,16'h01f4},
		'{KU,ST_EDIT,4'hd,7'h0,1,16'h01f5}, '{KE,ST_GRP,4'hd,7'h2,0,16'h0},
		'{KP,ST_MENU,4'hd,7'h0,0,16'h0}, '{KU,ST_MENU,4'he,7'h0,0,16'h0},
		'{KU,ST_MENU,4'hf,7'h0,0,16'h0}, '{KU,ST_MENU,4'h0,7'h0,0,16'h0},
		'{KP,ST_DISP,4'h0,7'h0,1,16'h1234}};
	logic [4:0] dins [5] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04};
	logic [4:0] terms [5] = '{5'h06, 5'h16, 5'h0e, 5'h06, 5'h07};
	// ==========================================================
	// design and operator
	logic mclk, rstn, factory_n, psel, penable, pwrite, pready, pslverr, fault_ack, err;
	kpm_keys_t keys;
	logic [4:0] din;
	logic [15:0] freq_in, curr_in, meter;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, gain_slot;
	kpm_disp_t disp;
	kpm_term_t term;
	int num_errors, comparisons, ack_cnt, a0;

	kpm_menu #(.DEB_CYC(DEB)) uut (.MCLK(mclk), .RSTN(rstn), .FACTORY_N(factory_n),
		.KEYS(keys), .DIN(din), .FREQ_IN(freq_in), .CURR_IN(curr_in), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DISP(disp),
		.TERM(term), .METER_OUT(meter), .FAULT_ACK(fault_ack));
	kpm_operator #(.HOLD(DEB + 4)) op (.mclk(mclk), .keys(keys));

	// clock and acknowledge pulse counter
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) if (fault_ack === 1'b1) ack_cnt <= ack_cnt + 1;
	// ==========================================================
	// helpers
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
	begin
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	end
	endtask

	task automatic chk_disp(input kpm_state_t m, input logic [3:0] e);
	begin
		check("mode", 32'(m), 32'(disp.mode));
		check("entry", 32'(e), 32'(disp.entry));
		check("lamp", 32'(m != ST_DISP), 32'(disp.prg_lamp));
	end
	endtask

	// one apb transfer; waits on pready but never past the bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
	begin
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			num_errors++;
			$display("apb wait ran out");
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask

	task automatic end_sim();
	begin
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask

	// a hung run counts as a mismatch
	initial
	begin
		repeat (100000) @(posedge mclk);
		num_errors++;
		$display("watchdog expired");
		end_sim();
	end
	// ==========================================================
	// main sequence
	initial
	begin
		rstn = 1'b0;
		factory_n = 1'b0;
		din = '0;
		freq_in = 16'h1234;
		curr_in = 16'h0456;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		num_errors = 0;
		comparisons = 0;
		ack_cnt = 0;
		repeat (2) @(posedge mclk);
		factory_n <= 1'b1;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4) @(posedge mclk);
		chk_disp(ST_DISP, 4'h0);
		for (int i = 0; i < 37; i++)
		begin
			op.press(32'(rows[i].key));
			chk_disp(rows[i].mode, rows[i].entry);
			if (rows[i].mode == ST_GRP) check("sub", 32'(rows[i].sub), 32'(disp.sub));
			if (rows[i].chk) check("value", 32'(rows[i].value), 32'(disp.value));
		end
		$display("test menu walk done");
		op.bounce(KP, 2);
		chk_disp(ST_DISP, 4'h0);
		op.press(KP);
		chk_disp(ST_GRP, 4'hd);
		check("sub", 32'h2, 32'(disp.sub));
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4) @(posedge mclk);
		chk_disp(ST_DISP, 4'h0);
		$display("test bounce and restore done");
		for (int i = 0; i < 5; i++)
		begin
			din <= dins[i];
			repeat (3) @(posedge mclk);
			check("term", 32'(terms[i]), 32'(term));
		end
		din <= 5'h01;
		repeat (3) @(posedge mclk);
		a0 = ack_cnt;
		op.press(KS);
		check("ack", 32'h1, 32'(ack_cnt - a0));
		check("fwd", 32'h0, 32'(term.run_fwd));
		din <= 5'h00;
		repeat (3) @(posedge mclk);
		din <= 5'h01;
		repeat (3) @(posedge mclk);
		check("fwd", 32'h1, 32'(term.run_fwd));
		$display("test terminals done");
		apb(1'b1, REG_PINDEX, 32'(4 + G_A * 96 + K_BASE_FREQ));
		apb(1'b0, REG_PDATA, '0);
		check("base", 32'h01f5, {16'h0, rd[15:0]});
		apb(1'b1, REG_PINDEX, 32'(B_ACCEL1));
		apb(1'b0, REG_PDATA, '0);
		check("accel", 32'h0065, {16'h0, rd[15:0]});
		gain_slot = 32'(4 + G_B * 96 + K_METER_GAIN);
		apb(1'b1, REG_PINDEX, gain_slot);
		apb(1'b0, REG_PDATA, '0);
		check("gain", 32'h0050, {16'h0, rd[15:0]});
		check("meter", 32'(freq_in) * 32'h50 / 32'h64, 32'(meter));
		apb(1'b1, REG_PINDEX, 32'(4 + G_C * 96 + K_METER_SEL));
		apb(1'b1, REG_PDATA, 32'h1);
		repeat (3) @(posedge mclk);
		check("meter", 32'(curr_in) * 32'h50 / 32'h64, 32'(meter));
		apb(1'b1, REG_PINDEX, gain_slot);
		apb(1'b1, REG_PDATA, 32'h64);
		repeat (3) @(posedge mclk);
		check("meter", 32'(curr_in), 32'(meter));
		apb(1'b0, REG_STATUS, '0);
		check("status", 32'h0059_0000, rd);
		apb(1'b0, REG_VALUE, '0);
		check("value reg", 32'(freq_in), rd);
		apb(1'b0, 8'h40, '0);
		check("slverr", 32'h1, 32'(err));
		check("unmapped", 32'h0, rd);
		$display("test registers done");
		end_sim();
	end
endmodule
`default_nettype wire
